// file: common/vse_defs.vh
`ifndef VSE_DEFS_VH
`define VSE_DEFS_VH
// crt register indices
`define VSE_IDX_OVERFLOW      8'h07
`define VSE_IDX_SYNC_START    8'h10
`define VSE_IDX_SYNC_END      8'h11
`define VSE_IDX_DISP_END      8'h12
`define VSE_IDX_PROT_LAST     8'h07
// io port addresses
`define VSE_PORT_INDEX_MONO   16'h03B4
`define VSE_PORT_DATA_MONO    16'h03B5
`define VSE_PORT_INDEX_COLOR  16'h03D4
`define VSE_PORT_DATA_COLOR   16'h03D5
// sync end control fields
`define VSE_BIT_PROTECT       7
`define VSE_BIT_RESERVED      6
`define VSE_BIT_IRQ_ENABLE    5
`define VSE_BIT_IRQ_CLEAR     4
`define VSE_END_MSB           3
// overflow bits
`define VSE_OVF_ALWAYS_WR     4
`define VSE_OVF_START_B9      7
`define VSE_OVF_START_B8      2
// reset values
`define VSE_RST_SYNC_END      8'h00
`define VSE_RST_GENERIC       8'h00
`endif

// file: hdl/vse_sync_end_cmp.v
`timescale 1ns/100ps
// vertical sync pulse generator, evaluated at line start
module vse_sync_end_cmp #(
  parameter LINE_W = 10
) (
  input  wire              core_clk_i,
  input  wire              reset_i,
  input  wire              line_start_i,
  input  wire [LINE_W-1:0] line_count_i,
  input  wire [LINE_W-1:0] sync_start_i,
  input  wire [3:0]        sync_end_i,
  output wire              vsync_o
);
  reg vsync_q;
  reg vsync_d;

  // start on match, end on low-nibble match; start wins a tie
  always @*
  begin
    vsync_d = vsync_q;
    if (line_start_i)
    begin
      if (line_count_i == sync_start_i)
        vsync_d = 1'b1;
      else if (line_count_i[3:0] == sync_end_i)
        vsync_d = 1'b0;
    end
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      vsync_q <= 1'b0;
    else
      vsync_q <= vsync_d;
  end

  assign vsync_o = vsync_q;
endmodule // vse_sync_end_cmp

// file: hdl/vse_crtc_regs.v
`timescale 1ns/100ps
`include "vse_defs.vh"
module vse_crtc_regs #(
  parameter LINE_W = 10
) (
  input  wire              core_clk_i,
  input  wire              reset_i,
  input  wire [15:0]       io_addr_i,
  input  wire              io_wr_i,
  input  wire              io_rd_i,
  input  wire [7:0]        io_wdata_i,
  output wire [7:0]        io_rdata_o,
  output wire              io_hit_o,
  input  wire              line_start_i,
  input  wire [LINE_W-1:0] line_count_i,
  output wire [7:0]        prot_timing_o,
  output wire [7:0]        overflow_o,
  output wire [7:0]        disp_end_low_o,
  output wire              vsync_o
);
  reg  [7:0]  index_q;
  reg  [7:0]  index_d;
  reg  [7:0]  prot_q [0:7];
  reg  [7:0]  sync_start_q;
  reg  [7:0]  sync_start_d;
  reg  [7:0]  sync_end_q;
  reg  [7:0]  sync_end_d;
  reg  [7:0]  disp_end_q;
  reg  [7:0]  disp_end_d;
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;
  wire        is_index;
  wire        is_data;
  wire        protect;
  wire        wr_data;
  wire [LINE_W-1:0] start_line;
  integer     i;

  // either port of a pair; mono and color share the registers
  function port_match;
    input [15:0] addr;
    input [15:0] mono;
    input [15:0] color;
    begin
      port_match = (addr == mono) || (addr == color);
    end
  endfunction

  // index falls in the lockable timing set 00h..07h
  // full 8-bit compare so aliases such as 08h are never locked
  function in_prot_set;
    input [7:0] idx;
    begin
      in_prot_set = (idx <= `VSE_IDX_PROT_LAST);
    end
  endfunction

  // new value of a protected byte for one data-port write
  function [7:0] prot_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input       locked;
    input       is_ovf;
    begin
      prot_merge = old_val;
      if (!locked)
        prot_merge = new_val;
      else if (is_ovf)
        prot_merge[`VSE_OVF_ALWAYS_WR] = new_val[`VSE_OVF_ALWAYS_WR];
    end
  endfunction

  // both mono and color port pairs decode to the same registers
  assign is_index = port_match(io_addr_i, `VSE_PORT_INDEX_MONO, `VSE_PORT_INDEX_COLOR);
  assign is_data  = port_match(io_addr_i, `VSE_PORT_DATA_MONO, `VSE_PORT_DATA_COLOR);
  assign io_hit_o = is_index || is_data;
  assign wr_data  = io_wr_i && is_data;
  assign protect  = sync_end_q[`VSE_BIT_PROTECT];

  // index next value; any byte is kept, unmapped ones just read zero
  always @*
  begin
    index_d = index_q;
    if (io_wr_i && is_index)
      index_d = io_wdata_i;
  end

  // index latch
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      index_q <= `VSE_RST_GENERIC;
    else
      index_q <= index_d;
  end

  // protected timing set, 00h..07h
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (i = 0; i < 8; i = i + 1)
        prot_q[i] <= `VSE_RST_GENERIC;
    end
    else if (wr_data && in_prot_set(index_q))
      prot_q[index_q[2:0]] <= prot_merge(prot_q[index_q[2:0]], io_wdata_i, protect, index_q == `VSE_IDX_OVERFLOW);
  end

  // next values of the config registers; 10h..12h ignore the lock
  always @*
  begin
    sync_start_d = sync_start_q;
    sync_end_d   = sync_end_q;
    disp_end_d   = disp_end_q;
    if (wr_data)
    begin
      case (index_q)
        `VSE_IDX_SYNC_START:
          sync_start_d = io_wdata_i;
        `VSE_IDX_SYNC_END:
          sync_end_d = io_wdata_i;
        `VSE_IDX_DISP_END:
          disp_end_d = io_wdata_i;
        default:
          sync_start_d = sync_start_q;
      endcase
    end
  end

  // sync start, sync end control and display end registers
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync_start_q <= `VSE_RST_GENERIC;
      sync_end_q   <= `VSE_RST_SYNC_END;
      disp_end_q   <= `VSE_RST_GENERIC;
    end
    else
    begin
      sync_start_q <= sync_start_d;
      sync_end_q   <= sync_end_d;
      disp_end_q   <= disp_end_d;
    end
  end

  // read mux; unmapped indices read zero so no stale byte leaks out
  always @*
  begin
    rdata_d = rdata_q;
    if (io_rd_i && is_index)
      rdata_d = index_q;
    else if (io_rd_i && is_data)
    begin
      if (in_prot_set(index_q))
        rdata_d = prot_q[index_q[2:0]];
      else
      begin
        case (index_q)
          `VSE_IDX_SYNC_START:
            rdata_d = sync_start_q;
          `VSE_IDX_SYNC_END:
            rdata_d = sync_end_q;
          `VSE_IDX_DISP_END:
            rdata_d = disp_end_q;
          default:
            rdata_d = `VSE_RST_GENERIC;
        endcase
      end
    end
  end

  // read data flop; holds until the next read strobe
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_q <= `VSE_RST_GENERIC;
    else
      rdata_q <= rdata_d;
  end
  assign io_rdata_o = rdata_q;

  assign start_line = {prot_q[7][`VSE_OVF_START_B9], prot_q[7][`VSE_OVF_START_B8], sync_start_q};

  // bits 6..4 intentionally feed nothing; no interrupt port exists
  // no interrupt path
  vse_sync_end_cmp #(
    .LINE_W (LINE_W)
  ) u_cmp (
    .core_clk_i   (core_clk_i),
    .reset_i      (reset_i),
    .line_start_i (line_start_i),
    .line_count_i (line_count_i),
    .sync_start_i (start_line),
    .sync_end_i   (sync_end_q[`VSE_END_MSB:0]),
    .vsync_o      (vsync_o)
  );

  // status views; the protected view follows the index latch
  assign prot_timing_o  = prot_q[index_q[2:0]];
  assign overflow_o     = prot_q[7];
  assign disp_end_low_o = disp_end_q;
endmodule // vse_crtc_regs

// file: tb/vse_crtc_regs_asserts.sv
`timescale 1ns/100ps
// port-level checks of the crt register block
module vse_crtc_regs_asserts #(parameter LINE_W = 10) (
  input wire              core_clk_i,
  input wire              reset_i,
  input wire [15:0]       io_addr_i,
  input wire              io_wr_i,
  input wire              io_rd_i,
  input wire [7:0]        io_wdata_i,
  input wire [7:0]        io_rdata_o,
  input wire              io_hit_o,
  input wire              line_start_i,
  input wire [LINE_W-1:0] line_count_i,
  input wire [7:0]        prot_timing_o,
  input wire [7:0]        overflow_o,
  input wire [7:0]        disp_end_low_o,
  input wire              vsync_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // registers only move on a write, read data only on a read, sync only at line start
  port_decode_a: assert property (io_hit_o == (io_addr_i[15:1] == 15'h01DA || io_addr_i[15:1] == 15'h01EA))
    else $error("port decode wrong");
  ovf_hold_a: assert property (!io_wr_i |=> $stable(overflow_o))
    else $error("overflow moved without write");
  dend_hold_a: assert property (!io_wr_i |=> $stable(disp_end_low_o))
    else $error("display end moved without write");
  prot_hold_a: assert property (!io_wr_i |=> $stable(prot_timing_o))
    else $error("protected view moved without write");
  rdata_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  sync_rise_a: assert property ($rose(vsync_o) |-> $past(line_start_i))
    else $error("sync rose off line start");
  sync_fall_a: assert property ($fell(vsync_o) |-> $past(line_start_i))
    else $error("sync fell off line start");
  sync_keep_a: assert property (!line_start_i |=> $stable(vsync_o))
    else $error("sync moved mid line");
endmodule // vse_crtc_regs_asserts
bind vse_crtc_regs vse_crtc_regs_asserts #(.LINE_W(LINE_W)) vse_crtc_regs_asserts_i (.*);

// file: tb/vse_crtc_regs_tb.sv
`timescale 1ns/100ps
module vse_crtc_regs_tb;
  reg        core_clk_i   = 1'b0;
  reg        reset_i      = 1'b1;
  reg [15:0] io_addr_i    = 16'h0000;
  reg        io_wr_i      = 1'b0;
  reg        io_rd_i      = 1'b0;
  reg [7:0]  io_wdata_i   = 8'h00;
  reg        line_start_i = 1'b0;
  reg [9:0]  line_count_i = 10'h000;
  wire [7:0] io_rdata_o, prot_timing_o, overflow_o, disp_end_low_o;
  wire       io_hit_o, vsync_o;
  integer    errors = 0, n_compared = 0, i;
  // 50 ns period
  always #25 core_clk_i = ~core_clk_i;
  vse_crtc_regs #(.LINE_W(10)) vse_crtc_regs_i (.*);
  // compare and count
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // one strobe cycle, results settled on return
  task acc(input w, input [15:0] a, input [7:0] d);
  begin
    @(posedge core_clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= w;
    io_rd_i <= !w;
    @(posedge core_clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    #1;
  end
  endtask
  task wreg(input [15:0] p, input [7:0] x, input [7:0] d);
  begin
    acc(1'b1, p, x);
    acc(1'b1, p + 16'h0001, d);
  end
  endtask
  task rreg(input string nm, input [7:0] x, input [7:0] e);
  begin
    acc(1'b1, 16'h03D4, x);
    acc(1'b0, 16'h03D5, 8'h00);
    chk(nm, io_rdata_o, e);
  end
  endtask
  // one scan line start, sync checked after it lands
  task line(input [9:0] l, input e);
  begin
    @(posedge core_clk_i);
    line_start_i <= 1'b1;
    line_count_i <= l;
    @(posedge core_clk_i);
    line_start_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("vsync", {7'h00, vsync_o}, {7'h00, e});
  end
  endtask
  task report_and_stop;
  begin
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rreg("end_ctrl", 8'h11, 8'h00);
    wreg(16'h03D4, 8'h07, 8'hA5);
    wreg(16'h03D4, 8'h11, 8'hF3);
    rreg("end_ctrl", 8'h11, 8'hF3);
    wreg(16'h03D4, 8'h07, 8'h5A);
    chk("overflow", overflow_o, 8'hB5);
    wreg(16'h03D4, 8'h00, 8'h77);
    rreg("reg00", 8'h00, 8'h00);
    wreg(16'h03B4, 8'h12, 8'h3C);
    chk("disp_end", disp_end_low_o, 8'h3C);
    chk("io_hit", {7'h00, io_hit_o}, 8'h01);
    rreg("unmapped", 8'h13, 8'h00);
    // start 320h from overflow b7,b2; end nibble 3, bits 6..4 set
    wreg(16'h03D4, 8'h10, 8'h20);
    for (i = 0; i < 9; i = i + 1)
      line(10'h31E + i[9:0], i >= 2 && i < 5);
    // bits 6..4 clear and unlocked: the pulse must not change
    wreg(16'h03D4, 8'h11, 8'h03);
    for (i = 0; i < 9; i = i + 1)
      line(10'h31E + i[9:0], i >= 2 && i < 5);
    wreg(16'h03D4, 8'h00, 8'h77);
    rreg("reg00", 8'h00, 8'h77);
    chk("prot_view", prot_timing_o, 8'h77);
    report_and_stop;
  end
endmodule // vse_crtc_regs_tb
